// [core/hbsc_consts.vh]
// Constants for the half-bridge serial control block.
// Assumes inclusion by bare name from the core design files.
`ifndef HBSC_CONSTS_VH
`define HBSC_CONSTS_VH

// Frame length in link clock cycles
`define HBSC_FRAME_BITS      16
`define HBSC_CNT_W           5

// Control word field positions
`define HBSC_CW_CLEAR        0
`define HBSC_CW_LS1          3
`define HBSC_CW_HS1          4
`define HBSC_CW_LS2          7
`define HBSC_CW_HS2          8
`define HBSC_CW_LS3          11
`define HBSC_CW_HS3          12
`define HBSC_CW_OPEN_N       13
`define HBSC_CW_DELAY        14
`define HBSC_CW_RUN          15

// Control word reset value: run, delay select, open-load off high
`define HBSC_CW_RESET        16'hE000

// Status frame field positions
`define HBSC_ST_PREWARN      0
`define HBSC_ST_SHORT        13
`define HBSC_ST_ENABLE       14
`define HBSC_ST_SUPPLY       15

// Status frame during thermal shutdown
`define HBSC_ST_ALL_HIGH     16'hFFFF

// Short-circuit shutdown delays in microseconds
`define HBSC_DLY_LONG_US     12000
`define HBSC_DLY_SHORT_US    1500
`define HBSC_CLK_MHZ         50

`endif

// [core/hbsc_sync.v]
// Two-flop synchroniser for one asynchronous level.
// Assumes the input comes from a pin outside the clk_i domain.
module hbsc_sync (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Level in and out
  input  wire din_i,
  input  wire rst_val_i,
  output wire dout_o
);

  reg meta_r;   // First stage, read only by second stage
  reg sync_r;   // Second stage, safe to use

  // Reset loads the pin's idle level, so an edge detector behind
  // this stage sees no false edge when reset lifts
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= rst_val_i;
      sync_r <= rst_val_i;
    end else begin
      meta_r <= din_i;
      sync_r <= meta_r;
    end
  end

  assign dout_o = sync_r;

endmodule // hbsc_sync

// [core/hbsc_delay.v]
// Short-circuit shutdown timer with a selectable delay.
// Assumes a fault level already synchronised to clk_i.
`include "hbsc_consts.vh"

module hbsc_delay #(
  parameter LONG_CYC  = `HBSC_DLY_LONG_US * `HBSC_CLK_MHZ,
  parameter SHORT_CYC = `HBSC_DLY_SHORT_US * `HBSC_CLK_MHZ
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Control
  input  wire fault_i,
  input  wire long_i,
  output reg  trip_o
);

  reg [19:0] cnt_r;   // Cycles the fault has persisted
  wire [19:0] lim;    // Selected limit

  assign lim = long_i ? LONG_CYC[19:0] : SHORT_CYC[19:0];

  // Count while the fault holds; pulse once at the limit
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 20'h00000;
      trip_o <= 1'b0;
    end else begin
      trip_o <= 1'b0;
      if (!fault_i) begin
        cnt_r <= 20'h00000;
      end else if (cnt_r + 20'h00001 >= lim) begin
        // Stays at limit so one trip per fault episode
        if (cnt_r != lim) begin
          trip_o <= 1'b1;
        end
        cnt_r <= lim;
      end else begin
        cnt_r <= cnt_r + 20'h00001;
      end
    end
  end

endmodule // hbsc_delay

// [core/hbsc_core.v]
// Serial control interface of a triple half-bridge driver.
// Assumes the host drives cs, sclk and serial_in as pins from
// another clock domain; fault inputs are analog comparator levels.
`include "hbsc_consts.vh"

// Every pin passes two flops on clk_i, so each link edge is seen
// two to three system cycles late; the link clock must stay well
// below a quarter of clk_i or edges merge. The status frame is frozen
// at select fall, so one frame never mixes old and new fault bits.
// Switch drives follow the applied word one cycle after it lands.
// Fault senses are levels; the short timer decides when a short
// is real, so brief spikes on the short sense lines are ignored.

module hbsc_core #(
  parameter LONG_CYC  = `HBSC_DLY_LONG_US * `HBSC_CLK_MHZ,
  parameter SHORT_CYC = `HBSC_DLY_SHORT_US * `HBSC_CLK_MHZ
) (
  // System clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Serial link pins
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire        serial_in_i,
  output reg         serial_out_o,
  output reg         serial_out_oe_o,
  // Hardware enable pin
  input  wire        enable_pin_i,
  // Fault sense levels
  input  wire        thermal_prewarning_i,
  input  wire        thermal_shutdown_i,
  input  wire        supply_fail_i,
  input  wire [5:0]  short_sense_i,
  input  wire [5:0]  open_load_i,
  // Switch drives: ls1,hs1,ls2,hs2,ls3,hs3 from bit 0 upward
  output reg  [5:0]  switch_on_o,
  // Settings to analog section
  output reg         open_load_check_n_o,
  output reg         short_delay_select_o,
  output reg         device_run_o
);

  // Synchronised pins, two flops behind their inputs
  wire        cs_s;            // Select level, high when idle
  wire        sclk_s;          // Link clock level
  wire        din_s;           // Host data level
  wire        en_s;            // Hardware enable level
  wire        tsd_s;           // Thermal shutdown level
  wire        psf_s;           // Supply fail level
  wire        pre_s;           // Thermal pre-warning level
  wire        sc_any_s;        // Any switch reports a short
  wire [5:0]  sc_s;            // Per-switch short levels
  wire [5:0]  ol_s;            // Per-switch open-load levels

  // Link state
  reg         cs_d_r;          // Previous cs level
  reg         sclk_d_r;        // Previous sclk level
  reg  [15:0] shift_in_r;      // Incoming bits
  reg  [15:0] shift_out_r;     // Outgoing status bits
  reg  [4:0]  cnt_r;           // Falling edges seen in frame

  // Control word and latched faults
  reg  [15:0] ctrl_r;          // bridge_control_word
  reg  [15:0] ctrl_nxt;        // Word applied at the next edge
  reg         short_flag_r;    // Latched short fault
  reg         supply_flag_r;   // Latched supply fail
  reg         thermal_flag_r;  // Latched thermal shutdown

  // Combinational helpers
  reg  [15:0] status;          // Assembled status frame
  wire        run_eff;         // Both enables high
  wire        trip;            // Short timer expired
  wire        cs_fall;         // Frame opens
  wire        cs_rise;         // Frame closes
  wire        sclk_fall;       // Input sampling edge
  wire        sclk_rise;       // Output shifting edge
  wire [5:0]  sw_bits;         // Switch bits from control word

  // Synchronisers for every asynchronous input
  // Select resets to its idle high so no false edge follows reset
  hbsc_sync u_cs   (.clk_i(clk_i), .rst_i(rst_i), .din_i(cs_n_i),
                    .rst_val_i(1'b1), .dout_o(cs_s));
  // Link clock and data idle low
  hbsc_sync u_sck  (.clk_i(clk_i), .rst_i(rst_i), .din_i(sclk_i),
                    .rst_val_i(1'b0), .dout_o(sclk_s));
  hbsc_sync u_din  (.clk_i(clk_i), .rst_i(rst_i), .din_i(serial_in_i),
                    .rst_val_i(1'b0), .dout_o(din_s));
  // Enable and fault levels; enable idles low so run starts late
  hbsc_sync u_en   (.clk_i(clk_i), .rst_i(rst_i), .din_i(enable_pin_i),
                    .rst_val_i(1'b0), .dout_o(en_s));
  hbsc_sync u_tsd  (.clk_i(clk_i), .rst_i(rst_i),
                    .din_i(thermal_shutdown_i),
                    .rst_val_i(1'b0), .dout_o(tsd_s));
  hbsc_sync u_psf  (.clk_i(clk_i), .rst_i(rst_i), .din_i(supply_fail_i),
                    .rst_val_i(1'b0), .dout_o(psf_s));
  hbsc_sync u_pre  (.clk_i(clk_i), .rst_i(rst_i),
                    .din_i(thermal_prewarning_i),
                    .rst_val_i(1'b0), .dout_o(pre_s));

  // Per-switch sense lines, each behind its own flops; the short
  // OR comes after them so no logic reads a raw pin
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sense
      // Open-load sense of switch gi
      hbsc_sync u_ol (.clk_i(clk_i), .rst_i(rst_i),
                      .din_i(open_load_i[gi]),
                      .rst_val_i(1'b0), .dout_o(ol_s[gi]));
      // Short sense of switch gi
      hbsc_sync u_sc (.clk_i(clk_i), .rst_i(rst_i),
                      .din_i(short_sense_i[gi]),
                      .rst_val_i(1'b0), .dout_o(sc_s[gi]));
    end
  endgenerate

  // Timer runs while any switch reports a short
  assign sc_any_s = |sc_s;

  // short delay timer, selected by bit 14
  // Counts in clk_i cycles; a short that clears early is forgotten
  hbsc_delay #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_dly (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .fault_i(sc_any_s),
    .long_i (ctrl_r[`HBSC_CW_DELAY]),
    .trip_o (trip)
  );

  // Edge detection on synchronised link pins
  // frame start edge
  assign cs_fall   = cs_d_r & ~cs_s;
  // frame end edge applies the word
  assign cs_rise   = ~cs_d_r & cs_s;
  // link clock edges; ignored while deselected
  assign sclk_fall = sclk_d_r & ~sclk_s & ~cs_s;
  assign sclk_rise = ~sclk_d_r & sclk_s & ~cs_s;

  // both enables must be high
  // Standby does not stop the link; it turns off the switches and device_run_o and clears status bit 14
  assign run_eff = en_s & ctrl_r[`HBSC_CW_RUN];

  // Switch bits packed ls1 first, hs3 last
  assign sw_bits = {ctrl_r[`HBSC_CW_HS3], ctrl_r[`HBSC_CW_LS3],
                    ctrl_r[`HBSC_CW_HS2], ctrl_r[`HBSC_CW_LS2],
                    ctrl_r[`HBSC_CW_HS1], ctrl_r[`HBSC_CW_LS1]};

  // Status frame assembly
  always @* begin
    status = 16'h0000;
    // status bit layout
    // Unused positions read low
    status[`HBSC_ST_PREWARN] = pre_s;
    // Switch state or open-load sense at the control positions
    status[`HBSC_CW_LS1]     = sw_bits[0] | ol_s[0];
    status[`HBSC_CW_HS1]     = sw_bits[1] | ol_s[1];
    status[`HBSC_CW_LS2]     = sw_bits[2] | ol_s[2];
    status[`HBSC_CW_HS2]     = sw_bits[3] | ol_s[3];
    status[`HBSC_CW_LS3]     = sw_bits[4] | ol_s[4];
    status[`HBSC_CW_HS3]     = sw_bits[5] | ol_s[5];
    // Latched faults and effective run
    status[`HBSC_ST_SHORT]   = short_flag_r;
    status[`HBSC_ST_ENABLE]  = run_eff;
    status[`HBSC_ST_SUPPLY]  = supply_flag_r;
    // thermal shutdown overrides everything
    // Host cannot tell which other fault bits are set meanwhile
    if (thermal_flag_r) begin
      status = `HBSC_ST_ALL_HIGH;
    end
  end

  // Next control word on frame end
  always @* begin
    ctrl_nxt = ctrl_r;
    // only a full frame is applied
    // A short frame is dropped whole; a long one keeps its last bits
    if (cs_rise && cnt_r >= `HBSC_FRAME_BITS) begin
      ctrl_nxt = shift_in_r;
    end
  end

  // Link shift logic and pin drive
  // One process owns every link register, so no edge is lost
  // between two processes seeing different cycles
  always @(posedge clk_i) begin
    if (rst_i) begin
      // Deselected and not driving
      cs_d_r          <= 1'b1;
      sclk_d_r        <= 1'b0;
      shift_in_r      <= 16'h0000;
      shift_out_r     <= 16'h0000;
      cnt_r           <= 5'h00;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      // Previous levels for edge detection
      cs_d_r   <= cs_s;
      sclk_d_r <= sclk_s;
      if (cs_fall) begin
        // start driving, first status bit out
        serial_out_oe_o <= 1'b1;
        serial_out_o    <= status[0];
        // Rest of the frame frozen here
        shift_out_r     <= {1'b0, status[15:1]};
        cnt_r           <= 5'h00;
      end else if (cs_s) begin
        serial_out_oe_o <= 1'b0;
      end
      if (sclk_fall) begin
        // sample on falling clock; LSB first in
        shift_in_r <= {din_s, shift_in_r[15:1]};
        // Saturates so an overlong frame still counts as full
        if (cnt_r != 5'h1F) begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
      // next bit only on rising clock, skip first rise
      // Bit 0 already stands from select fall, so the rise before
      // any fall would drop it
      if (sclk_rise && cnt_r != 5'h00) begin
        serial_out_o <= shift_out_r[0];
        shift_out_r  <= {1'b0, shift_out_r[15:1]};
      end
    end
  end

  // Control word register and latched fault flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r         <= `HBSC_CW_RESET;
      short_flag_r   <= 1'b0;
      supply_flag_r  <= 1'b0;
      thermal_flag_r <= 1'b0;
    end else begin
      // Word updates in standby too
      ctrl_r <= ctrl_nxt;
      // clear request; a new fault set wins
      // Clear loads live supply and thermal levels, so those faults still present
      // keep their flags; a standing short loses its flag, as trip only pulses
      if (cs_rise && cnt_r >= `HBSC_FRAME_BITS &&
          shift_in_r[`HBSC_CW_CLEAR]) begin
        short_flag_r   <= trip;
        supply_flag_r  <= psf_s;
        thermal_flag_r <= tsd_s;
      end else begin
        // Flags only accumulate between clears
        short_flag_r   <= short_flag_r | trip;
        supply_flag_r  <= supply_flag_r | psf_s;
        thermal_flag_r <= thermal_flag_r | tsd_s;
      end
    end
  end

  // Switch drive outputs, all off on short or thermal fault or standby
  // Registered so the pins never glitch while the word changes
  always @(posedge clk_i) begin
    if (rst_i) begin
      // switches off, check off, long delay
      switch_on_o          <= 6'h00;
      open_load_check_n_o  <= 1'b1;
      short_delay_select_o <= 1'b1;
      device_run_o         <= 1'b0;
    end else begin
      // gate off in standby
      // Latched short or thermal fault also holds them off
      if (run_eff && !thermal_flag_r && !short_flag_r) begin
        switch_on_o <= sw_bits;
      end else begin
        switch_on_o <= 6'h00;
      end
      open_load_check_n_o  <= ctrl_r[`HBSC_CW_OPEN_N];
      short_delay_select_o <= ctrl_r[`HBSC_CW_DELAY];
      device_run_o         <= run_eff;
    end
  end

endmodule // hbsc_core

// [verification/hbsc_core_sva.sv]
// Port checker for the serial control block.
// Assumes one clk_i domain; bound to the core at the foot.
module hbsc_core_sva (
  // Clock, reset, inputs
  input logic       clk_i,
  input logic       rst_i,
  input logic       cs_n_i,
  input logic       sclk_i,
  input logic       enable_pin_i,
  input logic       thermal_shutdown_i,
  // Outputs watched
  input logic       serial_out_o,
  input logic       serial_out_oe_o,
  input logic [5:0] switch_on_o,
  input logic       open_load_check_n_o,
  input logic       short_delay_select_o,
  input logic       device_run_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [3:0] since_r; // Cycles since a link edge, saturating
  // Restart on clock rise or select move; sync lag is 2-3 cycles
  always_ff @(posedge clk_i)
    if (rst_i || $rose(sclk_i) || $changed(cs_n_i)) since_r <= 4'h0;
    else if (since_r != 4'hF) since_r <= since_r + 4'h1;
  oe_idle_a: assert property (cs_n_i [*6] |-> !serial_out_oe_o)
    else $error("out driven while deselected");
  oe_drive_a: assert property (
    $fell(cs_n_i) ##1 !cs_n_i [*5] |-> serial_out_oe_o)
    else $error("out not driven in frame");
  out_edge_a: assert property (
    serial_out_oe_o && $changed(serial_out_o) |-> since_r < 4'h7)
    else $error("out moved off a clock rise");
  apply_cs_a: assert property (
    !cs_n_i [*8] |-> $stable(short_delay_select_o))
    else $error("setting moved in frame");
  reset_word_a: assert property (
    $fell(rst_i) |-> open_load_check_n_o && short_delay_select_o
      && switch_on_o == 6'h00)
    else $error("bad word after reset");
  run_pin_a: assert property (!enable_pin_i [*6] |-> !device_run_o)
    else $error("run with pin low");
  standby_off_a: assert property (
    !device_run_o [*3] |-> switch_on_o == 6'h00)
    else $error("switch on in standby");
  hot_off_a: assert property (
    thermal_shutdown_i [*6] |-> switch_on_o == 6'h00)
    else $error("switch on when hot");
  cover property ($rose(cs_n_i));
  cover property (thermal_shutdown_i && serial_out_oe_o);
  cover property (!enable_pin_i && !cs_n_i);
endmodule // hbsc_core_sva

bind hbsc_core hbsc_core_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
  .enable_pin_i(enable_pin_i), .thermal_shutdown_i(thermal_shutdown_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
  .switch_on_o(switch_on_o), .open_load_check_n_o(open_load_check_n_o),
  .short_delay_select_o(short_delay_select_o),
  .device_run_o(device_run_o));

// [verification/hbsc_host.sv]
// Host model: writes frames on the link pins, reads status back.
// Assumes clk_i at 50 MHz; pins move just after its falling edge.
module hbsc_host (
  // Clock and status pins
  input  logic clk_i,
  input  logic serial_out_i,
  input  logic serial_out_oe_i,
  // Link pins driven
  output logic cs_n_o,
  output logic sclk_o,
  output logic serial_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels: select pulled up, clock and data pulled down
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Frame of n clocks at 160 ns; surplus leading bits are ones
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] st);
    int i;
    int k;
    st = 16'h0000;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    step(8);
    for (i = 0; i < n; i++) begin
      k = i - ((n > 16) ? n - 16 : 0);
      serial_in_o = (k < 0) ? 1'b1 : w[k];
      sclk_o = 1'b1;
      step(4);
      // Bit settled since the rise, taken before the fall
      // Undriven line reads unknown, so it never matches
      if (i < 16) st[i] = serial_out_oe_i ? serial_out_i : 1'bx;
      sclk_o = 1'b0;
      step(4);
    end
    serial_in_o = 1'b0;
    cs_n_o = 1'b1;
    step(12);
  endtask
endmodule // hbsc_host

// [verification/half_bridge_serial_control_test.sv]
// Self-checking bench for the serial control block.
// Assumes core files, checker and host model compiled first.
module half_bridge_serial_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;  // 50 MHz clock
  logic        rst_i = 1'b1;  // Held 12 cycles
  logic        pin_en = 1'b1; // Hardware enable
  logic        warn = 1'b0;   // Fault levels
  logic        hot = 1'b0;
  logic        sup = 1'b0;
  logic [5:0]  shrt = 6'h00;
  logic [5:0]  opl = 6'h00;   // Open-load levels
  logic [15:0] st;            // Status read back
  logic [15:0] prv;           // Word in force
  wire         cs_n, sclk, sdi, sdo, sdo_oe, oln, dly, run;
  wire  [5:0]  sw;
  wire  [2:0]  cfg = {oln, dly, run};
  int          num_errors = 0;
  int          compares = 0;
  always #10 clk_i = ~clk_i;
  // Short delays scaled to 10 and 40 cycles
  hbsc_core #(.LONG_CYC(40), .SHORT_CYC(10)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
    .enable_pin_i(pin_en), .thermal_prewarning_i(warn),
    .thermal_shutdown_i(hot), .supply_fail_i(sup),
    .short_sense_i(shrt), .open_load_i(opl), .switch_on_o(sw),
    .open_load_check_n_o(oln), .short_delay_select_o(dly),
    .device_run_o(run));
  hbsc_host host (
    .clk_i(clk_i), .serial_out_i(sdo), .serial_out_oe_i(sdo_oe),
    .cs_n_o(cs_n), .sclk_o(sclk), .serial_in_o(sdi));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Status echoes switch bits; bit 14 is the effective run
  function automatic logic [15:0] st_of(input logic [15:0] w);
    return (w & 16'h1998) | {1'b0, w[15] & pin_en, 14'h0000};
  endfunction
  // Switch drives and settings implied by word a
  task automatic look(input logic [15:0] a);
    logic [5:0] e;
    e = {a[12], a[11], a[8], a[7], a[4], a[3]} & {6{a[15] & pin_en}};
    check({10'h0, sw}, {10'h0, e});
    check({13'h0, cfg}, {13'h0, a[13], a[14], a[15] & pin_en});
  endtask
  // One frame; x adds fault flags expected in the status
  task automatic put(input logic [15:0] w, input int n,
                     input logic [15:0] x);
    host.xfer(w, n, st);
    if (n >= 16) begin
      check(st, st_of(prv) | x);
      prv = w;
    end
    look(prv);
  endtask
  task automatic t_words;
    logic [15:0] ws [5] = '{16'h8018, 16'h8180, 16'h9800, 16'h6000,
                            16'h8018};
    prv = 16'hE000;
    look(prv);
    foreach (ws[i]) put(ws[i], 16, 16'h0000);
    $display("t_words done");
  endtask
  task automatic t_pin;
    pin_en = 1'b0;
    cyc(8);
    put(16'h8018, 16, 16'h0000);
    pin_en = 1'b1;
    cyc(8);
    look(prv);
    put(16'h8180, 15, 16'h0000);
    put(16'h8180, 17, 16'h0000);
    $display("t_pin done");
  endtask
  task automatic t_faults;
    shrt = 6'h04;
    cyc(20);
    shrt = 6'h00;
    check({10'h0, sw}, 16'h0000);
    sup = 1'b1;
    warn = 1'b1;
    cyc(8);
    sup = 1'b0;
    put(16'h8181, 16, 16'hA001);
    opl = 6'h20;
    put(16'hC180, 16, 16'h1001);
    opl = 6'h00;
    warn = 1'b0;
    shrt = 6'h04;
    cyc(20);
    shrt = 6'h00;
    look(prv);
    hot = 1'b1;
    cyc(8);
    host.xfer(16'hC180, 16, st);
    check(st, 16'hFFFF);
    $display("t_faults done");
  endtask
  initial begin
    cyc(12);
    rst_i = 1'b0;
    cyc(6);
    t_words();
    t_pin();
    t_faults();
    tally_and_finish();
  end
endmodule // half_bridge_serial_control_test
